// >>> hw/scd_seq.sv
`timescale 1ns/1ns
module scd_seq (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // control
    input  wire logic tick_i,
    input  wire logic en_i,
    input  wire logic start_i,
    // status
    output logic      busy_o,
    output logic      sample_o,
    output logic      done_o
);

    scd_pkg::scd_state_t state_r;
    logic [4:0]          cnt_r;
    logic                first_r;
    logic [4:0]          len;
    logic [4:0]          smp_at;

    assign len    = first_r ? scd_pkg::CONV_FIRST_TICKS : scd_pkg::CONV_NORMAL_TICKS;
    assign smp_at = first_r ? scd_pkg::SAMPLE_FIRST_AT : scd_pkg::SAMPLE_NORMAL_AT;
    assign busy_o = (state_r != scd_pkg::SCD_IDLE);

    // disabled converter re-arms the long first conversion
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !en_i) begin
            first_r <= 1'b1;
        end else if (done_o) begin
            first_r <= 1'b0;
        end
    end

    // conversion starts on the next converter tick after the request
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !en_i) begin
            state_r  <= scd_pkg::SCD_IDLE;
            cnt_r    <= 5'h00;
            sample_o <= 1'b0;
            done_o   <= 1'b0;
        end else begin
            sample_o <= 1'b0;
            done_o   <= 1'b0;
            unique case (state_r)
                scd_pkg::SCD_IDLE: begin
                    if (start_i) begin
                        state_r <= scd_pkg::SCD_WAIT;
                    end
                end
                scd_pkg::SCD_WAIT: begin
                    if (tick_i) begin
                        state_r <= scd_pkg::SCD_RUN;
                        cnt_r   <= 5'h01;
                    end
                end
                scd_pkg::SCD_RUN: begin
                    if (tick_i) begin
                        if (cnt_r == len) begin
                            state_r <= scd_pkg::SCD_IDLE;
                            done_o  <= 1'b1;
                        end else begin
                            cnt_r <= cnt_r + 5'h01;
                        end
                        sample_o <= (cnt_r == smp_at);
                    end
                end
                default: begin
                    state_r <= scd_pkg::SCD_IDLE;
                end
            endcase
        end
    end

endmodule : scd_seq

// >>> hw/scd_top.sv
`timescale 1ns/1ns
module scd_top (
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        NRST_I,
    // register port
    input  wire logic [3:0]  REG_ADDR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [7:0]  REG_RDATA_O,
    // pins and converter
    input  wire logic [11:0] PIN_DIG_I,
    input  wire logic [9:0]  ANA_RESULT_I,
    output logic             ANA_ENABLE_O,
    output logic      [5:0]  ANA_CHANNEL_O,
    output logic      [2:0]  ANA_REF_O,
    output logic      [1:0]  ANA_GAIN_O,
    output logic             ANA_GAIN_BYPASS_O,
    output logic             ANA_TEMP_SEL_O,
    output logic             ANA_SAMPLE_O,
    output logic             CONV_DONE_O,
    output logic      [11:0] DIG_BUF_DISABLE_O
);

    logic        en_r;
    logic        done_flag_r;
    logic [2:0]  ps_r;
    logic        grange_r;
    logic [2:0]  ref_r;
    logic        left_r;
    logic [5:0]  mux_r;
    logic [7:0]  dis_low_r;
    logic [3:0]  dis_high_r;
    logic [9:0]  result_r;
    logic        lock_r;
    logic        start_req_r;
    logic [7:0]  pscnt_r;
    logic        tick_r;
    logic [11:0] pin_s1_r;
    logic [11:0] pin_s2_r;
    logic [11:0] pin_s3_r;
    logic [11:0] pin_f_r;
    logic [1:0]  gain_nxt;
    logic [7:0]  ps_mask;
    logic [11:0] pin_masked;
    logic [7:0]  rdata_nxt;
    logic        busy;
    logic        wr_ctla;

    assign wr_ctla = REG_WR_I && (REG_ADDR_I == scd_pkg::ADDR_CTL_A);

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            en_r        <= 1'b0;
            ps_r        <= scd_pkg::PRESCALE_RST;
            start_req_r <= 1'b0;
        end else begin
            start_req_r <= 1'b0;
            if (wr_ctla) begin
                en_r        <= REG_WDATA_I[scd_pkg::CTLA_ENABLE];
                ps_r        <= REG_WDATA_I[2:0];
                start_req_r <= REG_WDATA_I[scd_pkg::CTLA_START] && REG_WDATA_I[scd_pkg::CTLA_ENABLE];
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            grange_r <= 1'b0;
            ref_r    <= scd_pkg::REF_RST;
            left_r   <= 1'b0;
            mux_r    <= scd_pkg::CHAN_RST;
        end else if (REG_WR_I && REG_ADDR_I == scd_pkg::ADDR_CTL_B) begin
            ref_r[2] <= REG_WDATA_I[scd_pkg::CTLB_REF2];
            mux_r[5] <= REG_WDATA_I[scd_pkg::CTLB_MUX5];
            grange_r <= REG_WDATA_I[scd_pkg::CTLB_GRANGE];
        end else if (REG_WR_I && REG_ADDR_I == scd_pkg::ADDR_IN_SEL) begin
            ref_r[1:0] <= REG_WDATA_I[7:6];
            left_r     <= REG_WDATA_I[scd_pkg::INSEL_LEFT];
            mux_r[4:0] <= REG_WDATA_I[4:0];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            done_flag_r <= 1'b0;
        end else if (CONV_DONE_O) begin
            done_flag_r <= 1'b1;
        end else if (wr_ctla && REG_WDATA_I[scd_pkg::CTLA_DONE]) begin
            done_flag_r <= 1'b0;
        end
    end

    // ****************************************
    // disable registers
    // ****************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            dis_low_r  <= scd_pkg::DIS_RST;
            dis_high_r <= scd_pkg::DIS_RST[7:4];
        end else if (REG_WR_I && REG_ADDR_I == scd_pkg::ADDR_DIS_LOW) begin
            dis_low_r <= REG_WDATA_I;
        end else if (REG_WR_I && REG_ADDR_I == scd_pkg::ADDR_DIS_HIGH) begin
            dis_high_r <= REG_WDATA_I[7:4];
        end
    end

    // bit 11 is the reference pin, 10:0 the analog pins
    assign DIG_BUF_DISABLE_O = {dis_low_r[scd_pkg::DISL_REFPIN], dis_high_r, dis_low_r[7:4], dis_low_r[2:0]};

    // ****************************************
    // pin input synchronisers
    // ****************************************
    for (genvar i = 0; i < 12; i++) begin : g_pin
        always_ff @(posedge CLK_SYS_I) begin
            if (!NRST_I) begin
                pin_s1_r[i] <= 1'b0;
                pin_s2_r[i] <= 1'b0;
                pin_s3_r[i] <= 1'b0;
                pin_f_r[i]  <= 1'b0;
            end else begin
                pin_s1_r[i] <= PIN_DIG_I[i];
                pin_s2_r[i] <= pin_s1_r[i];
                pin_s3_r[i] <= pin_s2_r[i];
                if (pin_s2_r[i] == pin_s3_r[i]) begin
                    pin_f_r[i] <= pin_s3_r[i];
                end
            end
        end
        assign pin_masked[i] = pin_f_r[i] && !DIG_BUF_DISABLE_O[i];
    end

    // ****************************************
    // prescaler and sequencer
    // ****************************************
    // held in reset while disabled so the first tick is a full period away
    assign ps_mask = 8'((9'h002 << ps_r) - 9'h001);

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I || !en_r) begin
            pscnt_r <= 8'h00;
            tick_r  <= 1'b0;
        end else begin
            pscnt_r <= pscnt_r + 8'h01;
            tick_r  <= ((pscnt_r & ps_mask) == ps_mask);
        end
    end

    scd_seq u_seq (
        .clk_i    (CLK_SYS_I),
        .nrst_i   (NRST_I),
        .tick_i   (tick_r),
        .en_i     (en_r),
        .start_i  (start_req_r),
        .busy_o   (busy),
        .sample_o (ANA_SAMPLE_O),
        .done_o   (CONV_DONE_O)
    );

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            ANA_ENABLE_O <= 1'b0;
        end else begin
            ANA_ENABLE_O <= en_r;
        end
    end

    // ****************************************
    // applied selection
    // ****************************************
    always_comb begin
        unique case ({grange_r, mux_r[0]})
            2'b00:   gain_nxt = scd_pkg::GAIN_1X;
            2'b01:   gain_nxt = scd_pkg::GAIN_8X;
            2'b10:   gain_nxt = scd_pkg::GAIN_20X;
            default: gain_nxt = scd_pkg::GAIN_32X;
        endcase
    end

    // frozen during a conversion so the input is stable while sampling
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            ANA_CHANNEL_O     <= scd_pkg::CHAN_RST;
            ANA_REF_O         <= scd_pkg::REF_RST;
            ANA_GAIN_O        <= scd_pkg::GAIN_1X;
            ANA_GAIN_BYPASS_O <= 1'b1;
            ANA_TEMP_SEL_O    <= 1'b0;
        end else if (en_r && !busy) begin
            ANA_CHANNEL_O     <= mux_r;
            ANA_REF_O         <= ref_r;
            ANA_TEMP_SEL_O    <= (mux_r == scd_pkg::CHAN_TEMP);
            if (mux_r <= scd_pkg::CHAN_SE_LAST || mux_r == scd_pkg::CHAN_TEMP) begin
                ANA_GAIN_BYPASS_O <= 1'b1;
                ANA_GAIN_O        <= scd_pkg::GAIN_1X;
            end else begin
                ANA_GAIN_BYPASS_O <= 1'b0;
                ANA_GAIN_O        <= gain_nxt;
            end
        end
    end

    // ****************************************
    // result and read lock
    // ****************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            lock_r <= 1'b0;
        end else if (REG_RD_I && REG_ADDR_I == scd_pkg::ADDR_RES_LOW) begin
            lock_r <= 1'b1;
        end else if (REG_RD_I && REG_ADDR_I == scd_pkg::ADDR_RES_HIGH) begin
            lock_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            result_r <= scd_pkg::RESULT_RST;
        end else if (CONV_DONE_O && !lock_r) begin
            result_r <= ANA_RESULT_I;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (REG_ADDR_I)
            scd_pkg::ADDR_DIS_LOW:  rdata_nxt = dis_low_r;
            scd_pkg::ADDR_DIS_HIGH: rdata_nxt = {dis_high_r, 4'h0};
            scd_pkg::ADDR_CTL_A:    rdata_nxt = {en_r, busy, 1'b0, done_flag_r, 1'b0, ps_r};
            scd_pkg::ADDR_CTL_B:    rdata_nxt = {3'h0, ref_r[2], mux_r[5], grange_r, 2'h0};
            scd_pkg::ADDR_IN_SEL:   rdata_nxt = {ref_r[1:0], left_r, mux_r[4:0]};
            scd_pkg::ADDR_RES_LOW:  rdata_nxt = left_r ? {result_r[1:0], 6'h00} : result_r[7:0];
            scd_pkg::ADDR_RES_HIGH: rdata_nxt = left_r ? result_r[9:2] : {6'h00, result_r[9:8]};
            scd_pkg::ADDR_PIN_LOW:  rdata_nxt = pin_masked[7:0];
            scd_pkg::ADDR_PIN_HIGH: rdata_nxt = {4'h0, pin_masked[11:8]};
            default:                rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            REG_RDATA_O <= 8'h00;
        end else begin
            REG_RDATA_O <= REG_RD_I ? rdata_nxt : 8'h00;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);

    lock_set_a: assert property (REG_RD_I && REG_ADDR_I == scd_pkg::ADDR_RES_LOW |=> lock_r)
        else $error("low byte read did not lock");
    result_hold_a: assert property (lock_r && CONV_DONE_O |=> $stable(result_r))
        else $error("locked result was overwritten");
    lock_release_a: assert property (REG_RD_I && REG_ADDR_I == scd_pkg::ADDR_RES_HIGH |=> !lock_r)
        else $error("high byte read did not unlock");
    flag_on_done_a: assert property (CONV_DONE_O |=> done_flag_r)
        else $error("done flag missing after conversion");
    start_clear_a: assert property (CONV_DONE_O |-> !busy ##1 !rdata_nxt[6] || REG_ADDR_I != scd_pkg::ADDR_CTL_A)
        else $error("start bit still set after completion");
    disable_stop_a: assert property (wr_ctla && !REG_WDATA_I[scd_pkg::CTLA_ENABLE] |=> ##1 !busy && !ANA_ENABLE_O)
        else $error("converter still active after disable");
    sel_frozen_a: assert property (!en_r |=> $stable(ANA_REF_O) && $stable(ANA_CHANNEL_O))
        else $error("selection applied while disabled");
    temp_route_a: assert property (ANA_CHANNEL_O == scd_pkg::CHAN_TEMP |-> ANA_TEMP_SEL_O && ANA_GAIN_BYPASS_O)
        else $error("temperature code not routed");
    pin_zero_a: assert property (REG_RD_I && REG_ADDR_I == scd_pkg::ADDR_PIN_LOW && dis_low_r[0]
                                 |=> !REG_RDATA_O[0])
        else $error("disabled pin read nonzero");

endmodule : scd_top

// >>> inc/scd_pkg.sv
package scd_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [3:0] ADDR_DIS_LOW  = 4'h1;
    localparam logic [3:0] ADDR_DIS_HIGH = 4'h2;
    localparam logic [3:0] ADDR_CTL_A    = 4'h3;
    localparam logic [3:0] ADDR_CTL_B    = 4'h4;
    localparam logic [3:0] ADDR_IN_SEL   = 4'h5;
    localparam logic [3:0] ADDR_RES_LOW  = 4'h6;
    localparam logic [3:0] ADDR_RES_HIGH = 4'h7;
    localparam logic [3:0] ADDR_PIN_LOW  = 4'h8;
    localparam logic [3:0] ADDR_PIN_HIGH = 4'h9;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTLA_ENABLE   = 7;
    localparam int CTLA_START    = 6;
    localparam int CTLA_DONE     = 4;
    localparam int CTLB_REF2     = 4;
    localparam int CTLB_MUX5     = 3;
    localparam int CTLB_GRANGE   = 2;
    localparam int INSEL_LEFT    = 5;
    localparam int DISL_REFPIN   = 3;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] DIS_RST      = 8'h00;
    localparam logic [9:0] RESULT_RST   = 10'h000;
    localparam logic [5:0] CHAN_RST     = 6'h00;
    localparam logic [2:0] REF_RST      = 3'h0;
    localparam logic [2:0] PRESCALE_RST = 3'h0;

    // ****************************************
    // channel and gain codes
    // ****************************************
    localparam logic [5:0] CHAN_SE_LAST = 6'h0A;
    localparam logic [5:0] CHAN_TEMP    = 6'h3F;
    localparam logic [1:0] GAIN_1X      = 2'h0;
    localparam logic [1:0] GAIN_8X      = 2'h1;
    localparam logic [1:0] GAIN_20X     = 2'h2;
    localparam logic [1:0] GAIN_32X     = 2'h3;

    // ****************************************
    // timing, in converter clock ticks
    // ****************************************
    localparam logic [4:0] CONV_NORMAL_TICKS = 5'h0D;
    localparam logic [4:0] CONV_FIRST_TICKS  = 5'h19;
    localparam logic [4:0] SAMPLE_NORMAL_AT  = 5'h02;
    localparam logic [4:0] SAMPLE_FIRST_AT   = 5'h0E;

    typedef enum logic [1:0] {
        SCD_IDLE = 2'h0,
        SCD_WAIT = 2'h1,
        SCD_RUN  = 2'h3
    } scd_state_t;

endpackage : scd_pkg

// >>> verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;

    // ****************************************
    // clock, reset and stimulus signals
    // ****************************************
    logic        clk_sys     = 1'b0;
    logic        nrst        = 1'b0;
    logic [3:0]  reg_addr    = 4'h0;
    logic [7:0]  reg_wdata   = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [7:0]  reg_rdata;
    logic [11:0] pin_dig     = 12'hB5E;
    logic [9:0]  ana_result  = 10'h000;
    logic        ana_enable;
    logic [5:0]  ana_channel;
    logic [2:0]  ana_ref;
    logic [1:0]  ana_gain;
    logic        ana_bypass;
    logic        ana_temp;
    logic        conv_done;
    logic [11:0] buf_disable;
    logic        ana_sample;
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          cyc             = 0;
    int          done_cnt        = 0;
    int          smp_cnt         = 0;
    int          smp_cyc         = 0;

    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (conv_done === 1'b1) begin
            done_cnt <= done_cnt + 1;
        end
        if (ana_sample === 1'b1) begin
            smp_cnt <= smp_cnt + 1;
            smp_cyc <= cyc;
        end
    end

    scd_top dut (
        .CLK_SYS_I         (clk_sys),
        .NRST_I            (nrst),
        .REG_ADDR_I        (reg_addr),
        .REG_WDATA_I       (reg_wdata),
        .REG_WR_I          (reg_wr),
        .REG_RD_I          (reg_rd),
        .REG_RDATA_O       (reg_rdata),
        .PIN_DIG_I         (pin_dig),
        .ANA_RESULT_I      (ana_result),
        .ANA_ENABLE_O      (ana_enable),
        .ANA_CHANNEL_O     (ana_channel),
        .ANA_REF_O         (ana_ref),
        .ANA_GAIN_O        (ana_gain),
        .ANA_GAIN_BYPASS_O (ana_bypass),
        .ANA_TEMP_SEL_O    (ana_temp),
        .ANA_SAMPLE_O      (ana_sample),
        .CONV_DONE_O       (conv_done),
        .DIG_BUF_DISABLE_O (buf_disable)
    );

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // whole run is several hundred cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        conclude();
    end

    // ****************************************
    // register port tasks
    // ****************************************
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cycles

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(name, {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rdc

    // disable bits to pin order: ref pin, pins 10..7, pins 6..3, pins 2..0
    function automatic logic [11:0] dis_map(input logic [7:0] lo, input logic [7:0] hi);
        return {lo[3], hi[7:4], lo[7:4], lo[2:0]};
    endfunction : dis_map

    // start bit and done clear in one write, enable set; sampling sits eleven ticks before the end
    task automatic convert(input logic [9:0] val, input int ticks, input logic [2:0] ps);
        int t0;
        int n;
        int s0;
        @(posedge clk_sys);
        ana_result <= val;
        wr(scd_pkg::ADDR_CTL_A, {5'b11010, ps});
        #1;
        t0 = cyc;
        s0 = smp_cnt;
        rdc(scd_pkg::ADDR_CTL_A, {5'b11000, ps}, "ctl_busy");
        while (conv_done !== 1'b1 && cyc - t0 < 200) begin
            @(posedge clk_sys);
            #1;
        end
        n = cyc - t0;
        chk("conv_cycles", 16'(n >= (2 << ps) * ticks && n <= (2 << ps) * ticks + 8), 16'h0001);
        chk("sample_cnt", 16'(smp_cnt - s0), 16'h0001);
        chk("sample_pos", 16'(cyc - smp_cyc), 16'((2 << ps) * 11));
        wait_cycles(2);
        rdc(scd_pkg::ADDR_CTL_A, {5'b10010, ps}, "ctl_done");
    endtask : convert

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [2:0] k;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        wait_cycles(1);
        chk("bypass_rst", {15'h0, ana_bypass}, 16'h0001);
        chk("enable_rst", {15'h0, ana_enable}, 16'h0000);
        chk("bufdis_rst", {4'h0, buf_disable}, 16'h0000);
        rdc(scd_pkg::ADDR_DIS_LOW, 8'h00, "dis_low_rst");
        rdc(scd_pkg::ADDR_DIS_HIGH, 8'h00, "dis_high_rst");

        wr(scd_pkg::ADDR_DIS_LOW, 8'hAD);
        wr(scd_pkg::ADDR_DIS_HIGH, 8'h5F);
        rdc(scd_pkg::ADDR_DIS_LOW, 8'hAD, "dis_low");
        rdc(scd_pkg::ADDR_DIS_HIGH, 8'h50, "dis_high");
        chk("bufdis", {4'h0, buf_disable}, {4'h0, dis_map(8'hAD, 8'h50)});
        // pins pass a synchroniser, so give them time to settle
        wait_cycles(6);
        rdc(scd_pkg::ADDR_PIN_LOW, 8'(~dis_map(8'hAD, 8'h50) & pin_dig), "pin_low");
        rdc(scd_pkg::ADDR_PIN_HIGH, {4'h0, 4'((~dis_map(8'hAD, 8'h50) & pin_dig) >> 8)}, "pin_high");
        @(posedge clk_sys);
        pin_dig <= 12'h4A1;
        wait_cycles(6);
        rdc(scd_pkg::ADDR_PIN_LOW, 8'(~dis_map(8'hAD, 8'h50) & pin_dig), "pin_low_new");
        rdc(4'hF, 8'h00, "unmapped");

        wr(scd_pkg::ADDR_IN_SEL, 8'hC5);
        wr(scd_pkg::ADDR_CTL_A, 8'h40);
        wait_cycles(60);
        chk("chan_off", {10'h0, ana_channel}, 16'h0000);
        chk("ref_off", {13'h0, ana_ref}, 16'h0000);
        chk("enable_off", {15'h0, ana_enable}, 16'h0000);
        chk("done_off", 16'(done_cnt), 16'h0000);
        wr(scd_pkg::ADDR_CTL_A, 8'h80);
        wait_cycles(3);
        chk("enable_on", {15'h0, ana_enable}, 16'h0001);
        chk("chan_on", {10'h0, ana_channel}, 16'h0005);
        chk("ref_on", {13'h0, ana_ref}, 16'h0003);
        chk("bypass_se", {15'h0, ana_bypass}, 16'h0001);

        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            wr(scd_pkg::ADDR_CTL_B, {3'b000, ~k[2], 1'b0, k[1], 2'b00});
            wr(scd_pkg::ADDR_IN_SEL, {~k[1:0], 1'b0, 4'h8, k[0]});
            wait_cycles(3);
            chk("gain", {14'h0, ana_gain}, {14'h0, k[1:0]});
            chk("ref", {13'h0, ana_ref}, {13'h0, ~k});
            chk("bypass_diff", {15'h0, ana_bypass}, 16'h0000);
        end
        wr(scd_pkg::ADDR_CTL_B, 8'h08);
        wr(scd_pkg::ADDR_IN_SEL, 8'h1F);
        wait_cycles(3);
        chk("temp_sel", {14'h0, ana_temp, ana_bypass}, 16'h0003);
        chk("temp_chan", {10'h0, ana_channel}, 16'h003F);
        wr(scd_pkg::ADDR_CTL_B, 8'h00);
        wr(scd_pkg::ADDR_IN_SEL, 8'h0A);
        wait_cycles(3);
        chk("se_last", {8'h0, ana_channel, ana_temp, ana_bypass}, 16'h0029);

        convert(10'h2A5, 25, 3'h0);
        rdc(scd_pkg::ADDR_RES_LOW, 8'hA5, "res_low_r");
        rdc(scd_pkg::ADDR_RES_HIGH, 8'h02, "res_high_r");
        wr(scd_pkg::ADDR_IN_SEL, 8'h2A);
        rdc(scd_pkg::ADDR_RES_LOW, 8'h40, "res_low_l");
        rdc(scd_pkg::ADDR_RES_HIGH, 8'hA9, "res_high_l");
        wr(scd_pkg::ADDR_IN_SEL, 8'h0A);

        // low read locks; the next result must be lost but still flagged
        rdc(scd_pkg::ADDR_RES_LOW, 8'hA5, "lock_low");
        convert(10'h15A, 13, 3'h0);
        rdc(scd_pkg::ADDR_RES_HIGH, 8'h02, "lock_high");
        rdc(scd_pkg::ADDR_RES_LOW, 8'hA5, "lock_low2");
        rdc(scd_pkg::ADDR_RES_HIGH, 8'h02, "lock_high2");
        convert(10'h15A, 13, 3'h0);
        rdc(scd_pkg::ADDR_RES_LOW, 8'h5A, "new_low");
        rdc(scd_pkg::ADDR_RES_HIGH, 8'h01, "new_high");

        // disabling mid-conversion aborts it and re-arms the long first conversion
        wr(scd_pkg::ADDR_CTL_A, 8'hC0);
        wait_cycles(12);
        rdc(scd_pkg::ADDR_CTL_A, 8'hD0, "abort_busy");
        wr(scd_pkg::ADDR_CTL_A, 8'h00);
        wait_cycles(60);
        rdc(scd_pkg::ADDR_CTL_A, 8'h10, "abort_idle");
        chk("abort_done", 16'(done_cnt), 16'h0003);
        convert(10'h3C3, 25, 3'h1);
        rdc(scd_pkg::ADDR_RES_LOW, 8'hC3, "rearm_low");
        rdc(scd_pkg::ADDR_RES_HIGH, 8'h03, "rearm_high");

        wr(scd_pkg::ADDR_CTL_A, 8'h00);
        wait_cycles(3);
        chk("enable_clr", {15'h0, ana_enable}, 16'h0000);
        conclude();
    end

endmodule : tb_top
